// ==== inc/bmx_defs.vh ====
`ifndef BMX_DEFS_VH
`define BMX_DEFS_VH

// ****************************************
// matrix shape
// ****************************************
`define BMX_NM 6
`define BMX_NS 5
`define BMX_AW 32
`define BMX_DW 32

// ****************************************
// slave port codes
// ****************************************
`define BMX_SL_SRAM0 3'h0
`define BMX_SL_SRAM1 3'h1
`define BMX_SL_ROM 3'h2
`define BMX_SL_EBI 3'h3
`define BMX_SL_PERIPH 3'h4
`define BMX_SL_NONE 3'h7

// ****************************************
// address map: 256 mbyte banks, 1 mbyte internal areas
// ****************************************
`define BMX_BANK_MSB 31
`define BMX_BANK_LSB 28
`define BMX_AREA_MSB 27
`define BMX_AREA_LSB 20
`define BMX_BANK_INT 4'h0
`define BMX_BANK_EXT_LO 4'h1
`define BMX_BANK_EXT_HI 4'h7
`define BMX_BANK_PERIPH 4'hf
`define BMX_AREA_BOOT 8'h00
`define BMX_AREA_ROM 8'h01
`define BMX_AREA_SRAM0 8'h02
`define BMX_AREA_SRAM1 8'h03
`define BMX_AREA_UHP 8'h05

// ****************************************
// master indices
// ****************************************
`define BMX_M_IFETCH 3'h0
`define BMX_M_CPU_DATA 3'h1
`define BMX_M_PERIPH_DMA 3'h2
`define BMX_M_IMAGE 3'h3
`define BMX_M_ETH 3'h4
`define BMX_M_USB_HOST 3'h5
`define BMX_M_FIRST_RESTRICTED 3'h3

// ****************************************
// arbitration settings
// ****************************************
`define BMX_POL_FIXED 1'b0
`define BMX_POL_RR 1'b1
`define BMX_DEF_NONE 2'h0
`define BMX_DEF_LAST 2'h1
`define BMX_DEF_FIXED 2'h2
`define BMX_SLOT_UNLIMITED 8'h00

// ****************************************
// chip configuration and boot reset values
// ****************************************
`define BMX_VSEL_3V3 1'b0
`define BMX_VSEL_1V8 1'b1
`define BMX_SLEW_FAST 1'b0
`define BMX_SLEW_SLOW 1'b1
`define BMX_BOOT_RST 1'b1

`endif

// ==== hdl/bmx_arbiter.v ====
`timescale 1ns/100ps
`default_nettype none
`include "bmx_defs.vh"

// combinational grant choice for one slave port
module bmx_arbiter (
  input wire [5:0] req,
  input wire policy,
  input wire [1:0] def_mode,
  input wire [2:0] def_mstr,
  input wire [2:0] last_mstr,
  output reg gnt_valid,
  output reg [2:0] gnt
);

  integer i;
  integer j;
  reg [2:0] dflt;

  // ****************************************
  // grant selection
  // ****************************************
  // under round robin the default master wins at once so a parked master pays no arbitration penalty
  always @* begin
    gnt_valid = 1'b0;
    gnt = 3'h0;
    dflt = (def_mode == `BMX_DEF_FIXED) ? def_mstr : last_mstr;
    j = 0;
    if (policy == `BMX_POL_FIXED) begin
      // lowest index wins
      for (i = 5; i >= 0; i = i - 1) begin
        if (req[i]) begin
          gnt_valid = 1'b1;
          gnt = i[2:0];
        end
      end
    end else if (def_mode != `BMX_DEF_NONE && dflt < 3'h6 && req[dflt]) begin
      gnt_valid = 1'b1;
      gnt = dflt;
    end else begin
      // round robin, starting after the last owner
      for (i = 5; i >= 0; i = i - 1) begin
        j = {29'h0, last_mstr} + 1 + i;
        if (j >= 6) begin
          j = j - 6;
        end
        if (req[j]) begin
          gnt_valid = 1'b1;
          gnt = j[2:0];
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== hdl/bmx_matrix.v ====
`timescale 1ns/100ps
`default_nettype none
`include "bmx_defs.vh"

//
// Contract
// - six masters run concurrent accesses whenever their target slaves differ
// - every master has its own decoder, all decoding the same map
// - every slave has its own arbiter with independent settings
// - fixed or round robin; under round robin a default master of none, last or fixed
// - bursts, undefined-length ones too, break at a slot limit; a limit of 0 lets them run on
// - masters 3 to 5 have no path to rom, usb registers or peripherals
// - all masters reach both srams and external bus; 0 to 2 reach all
// - boot area selects internal boot, external boot or remapped slave
// - boot select pin captured once at reset and held
// - remap puts internal sram where boot memory was
// - voltage range resets to 3.3v; software sets it before fast clocks
// - slew rate resets to fast, kept beside voltage range
// - unmapped or unwired access ends with abort to that master
// - captured 1 boots from rom, 0 from external chip select 0
// - with remap set, boot pin ignored and sram0 at zero
// - sixteen 256 mbyte banks: 0 internal, 1 to 7 external, 15 peripherals
module bmx_matrix (
  input wire MCLK,
  input wire RESET_N,
  input wire [5:0] M_REQ,
  input wire [191:0] M_ADDR,
  input wire [5:0] M_WRITE,
  input wire [191:0] M_WDATA,
  input wire [5:0] M_LAST,
  output reg [5:0] M_DONE,
  output reg [5:0] M_ABORT,
  output reg [191:0] M_RDATA,
  output wire [4:0] S_REQ,
  output wire [159:0] S_ADDR,
  output wire [4:0] S_WRITE,
  output wire [159:0] S_WDATA,
  output wire [14:0] S_MASTER,
  input wire [159:0] S_RDATA,
  input wire [4:0] S_READY,
  input wire [4:0] ARB_POLICY,
  input wire [9:0] ARB_DEF_MODE,
  input wire [14:0] ARB_DEF_MASTER,
  input wire [39:0] ARB_SLOT_LIMIT,
  input wire REMAP,
  input wire BOOT_SELECT_PIN,
  output reg BOOT_SELECT_CAPTURED,
  input wire CFG_WRITE,
  input wire CFG_VOLTAGE_IN,
  input wire CFG_SLEW_IN,
  output reg EXT_BUS_VOLTAGE_SELECT,
  output reg EXT_BUS_SLEW_SELECT
);

  localparam ST_IDLE = 1'b0;
  localparam ST_XFER = 1'b1;

  reg cap_done_r;
  wire [17:0] dec;
  wire [4:0] fin;
  wire [14:0] own;
  reg [5:0] done_nxt;
  reg [5:0] abort_nxt;
  reg [191:0] rdata_nxt;
  integer m;
  integer s;

  // ****************************************
  // address decode
  // ****************************************
  // one map for every master; only the path check depends on the index
  function [2:0] bmx_decode;
    input [31:0] addr;
    input integer mstr;
    input remap;
    input boot_rom;
    reg [3:0] bank;
    reg [7:0] area;
    reg [2:0] sl;
    begin
      bank = addr[`BMX_BANK_MSB:`BMX_BANK_LSB];
      area = addr[`BMX_AREA_MSB:`BMX_AREA_LSB];
      sl = `BMX_SL_NONE;
      if (bank == `BMX_BANK_INT) begin
        case (area)
          `BMX_AREA_BOOT: begin
            if (remap) begin
              sl = `BMX_SL_SRAM0;
            end else if (boot_rom) begin
              sl = `BMX_SL_ROM;
            end else begin
              sl = `BMX_SL_EBI;
            end
          end
          `BMX_AREA_ROM: sl = `BMX_SL_ROM;
          `BMX_AREA_SRAM0: sl = `BMX_SL_SRAM0;
          `BMX_AREA_SRAM1: sl = `BMX_SL_SRAM1;
          `BMX_AREA_UHP: sl = `BMX_SL_ROM;
          default: sl = `BMX_SL_NONE;
        endcase
      end else if (bank >= `BMX_BANK_EXT_LO && bank <= `BMX_BANK_EXT_HI) begin
        sl = `BMX_SL_EBI;
      end else if (bank == `BMX_BANK_PERIPH) begin
        sl = `BMX_SL_PERIPH;
      end
      // the dma-only masters have no wire to rom, usb registers or peripherals
      if (mstr >= `BMX_M_FIRST_RESTRICTED && (sl == `BMX_SL_ROM || sl == `BMX_SL_PERIPH)) begin
        sl = `BMX_SL_NONE;
      end
      bmx_decode = sl;
    end
  endfunction

  // one decoder instance per master port
  genvar gm;
  generate
    for (gm = 0; gm < 6; gm = gm + 1) begin : g_dec
      assign dec[gm*3 +: 3] = bmx_decode(M_ADDR[gm*32 +: 32], gm, REMAP, BOOT_SELECT_CAPTURED);
    end
  endgenerate

  // ****************************************
  // boot select capture and chip configuration
  // ****************************************
  // the pin is taken on the first edge after reset release and never again,
  // so a later change on the strap cannot move the boot memory
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cap_done_r <= 1'b0;
      BOOT_SELECT_CAPTURED <= `BMX_BOOT_RST;
    end else if (!cap_done_r) begin
      cap_done_r <= 1'b1;
      BOOT_SELECT_CAPTURED <= BOOT_SELECT_PIN;
    end
  end

  // voltage range and slew live together; written as a pair
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      EXT_BUS_VOLTAGE_SELECT <= `BMX_VSEL_3V3;
      EXT_BUS_SLEW_SELECT <= `BMX_SLEW_FAST;
    end else if (CFG_WRITE) begin
      EXT_BUS_VOLTAGE_SELECT <= CFG_VOLTAGE_IN;
      EXT_BUS_SLEW_SELECT <= CFG_SLEW_IN;
    end
  end

  // ****************************************
  // slave ports, each with its own arbiter
  // ****************************************
  genvar gs;
  generate
    for (gs = 0; gs < 5; gs = gs + 1) begin : g_sl
      reg state_r;
      reg [2:0] own_r;
      reg [2:0] last_r;
      reg locked_r;
      reg [7:0] beats_r;
      reg req_r;
      reg [31:0] addr_r;
      reg wr_r;
      reg [31:0] wdata_r;
      reg [5:0] cand;
      wire gnt_valid;
      wire [2:0] gnt;
      wire [7:0] slot;
      wire [7:0] beats_inc;
      integer k;

      assign slot = ARB_SLOT_LIMIT[gs*8 +: 8];
      assign beats_inc = beats_r + 8'h01;

      // masters aimed here; a master seeing done or abort this cycle is still
      // showing its old request, so it is held out for that one cycle
      always @* begin
        cand = 6'h00;
        for (k = 0; k < 6; k = k + 1) begin
          cand[k] = M_REQ[k] & ({29'h0, dec[k*3 +: 3]} == gs) & ~M_DONE[k] & ~M_ABORT[k];
        end
      end

      bmx_arbiter u_arb (
        .req(cand),
        .policy(ARB_POLICY[gs]),
        .def_mode(ARB_DEF_MODE[gs*2 +: 2]),
        .def_mstr(ARB_DEF_MASTER[gs*3 +: 3]),
        .last_mstr(last_r),
        .gnt_valid(gnt_valid),
        .gnt(gnt)
      );

      // slave sequencer: grant, wait for ready, then release or keep the burst
      always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
          state_r <= ST_IDLE;
          own_r <= 3'h0;
          last_r <= 3'h0;
          locked_r <= 1'b0;
          beats_r <= 8'h00;
          req_r <= 1'b0;
          addr_r <= 32'h0;
          wr_r <= 1'b0;
          wdata_r <= 32'h0;
        end else begin
          case (state_r)
            ST_IDLE: begin
              if (locked_r && cand[own_r]) begin
                // burst continues with its owner
                state_r <= ST_XFER;
                req_r <= 1'b1;
                addr_r <= M_ADDR[own_r*32 +: 32];
                wr_r <= M_WRITE[own_r];
                wdata_r <= M_WDATA[own_r*32 +: 32];
              end else if (locked_r && M_DONE[own_r]) begin
                // owner is presenting its next beat next cycle
                state_r <= ST_IDLE;
              end else if (gnt_valid) begin
                state_r <= ST_XFER;
                locked_r <= 1'b0;
                beats_r <= 8'h00;
                own_r <= gnt;
                req_r <= 1'b1;
                addr_r <= M_ADDR[gnt*32 +: 32];
                wr_r <= M_WRITE[gnt];
                wdata_r <= M_WDATA[gnt*32 +: 32];
              end else begin
                // an owner gone quiet ends its burst
                locked_r <= 1'b0;
                beats_r <= 8'h00;
              end
            end
            ST_XFER: begin
              if (S_READY[gs]) begin
                state_r <= ST_IDLE;
                req_r <= 1'b0;
                last_r <= own_r;
                if (M_LAST[own_r] || (slot != `BMX_SLOT_UNLIMITED && beats_inc >= slot)) begin
                  locked_r <= 1'b0;
                  beats_r <= 8'h00;
                end else begin
                  locked_r <= 1'b1;
                  beats_r <= beats_inc;
                end
              end
            end
            default: begin
              state_r <= ST_IDLE;
              req_r <= 1'b0;
            end
          endcase
        end
      end

      assign fin[gs] = (state_r == ST_XFER) & S_READY[gs];
      assign own[gs*3 +: 3] = own_r;
      assign S_REQ[gs] = req_r;
      assign S_ADDR[gs*32 +: 32] = addr_r;
      assign S_WRITE[gs] = wr_r;
      assign S_WDATA[gs*32 +: 32] = wdata_r;
      assign S_MASTER[gs*3 +: 3] = own_r;
    end
  endgenerate

  // ****************************************
  // master answers
  // ****************************************
  // a master targets one slave at a time, so at most one slave finishes for it
  always @* begin
    done_nxt = 6'h00;
    rdata_nxt = M_RDATA;
    for (s = 0; s < 5; s = s + 1) begin
      if (fin[s]) begin
        done_nxt[own[s*3 +: 3]] = 1'b1;
        rdata_nxt[own[s*3 +: 3]*32 +: 32] = S_RDATA[s*32 +: 32];
      end
    end
    for (m = 0; m < 6; m = m + 1) begin
      // the done cycle still shows the old request, so it is masked like the abort cycle
      abort_nxt[m] = M_REQ[m] & (dec[m*3 +: 3] == `BMX_SL_NONE) & ~M_ABORT[m] & ~M_DONE[m];
    end
  end

  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      M_DONE <= 6'h00;
      M_ABORT <= 6'h00;
      M_RDATA <= 192'h0;
    end else begin
      M_DONE <= done_nxt;
      M_ABORT <= abort_nxt;
      M_RDATA <= rdata_nxt;
    end
  end

endmodule

`default_nettype wire

// ==== testbench/bmx_slave_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// five slave responders
// ****************************************
module bmx_slave_model (
  input wire logic MCLK,
  input wire logic [4:0] S_REQ,
  input wire logic [159:0] S_ADDR,
  input wire logic [4:0] S_WRITE,
  input wire logic [159:0] S_WDATA,
  input wire logic [4:0] SLOW,
  output logic [159:0] S_RDATA,
  output logic [4:0] S_READY
);
  int cnt [5];
  initial begin
    S_READY = '0;
    S_RDATA = '0;
  end
  // ready after one or three cycles; idle data toggles so a stale sample never passes
  always @(posedge MCLK) begin
    for (int s = 0; s < 5; s++) begin
      if (S_REQ[s] && !S_READY[s] && cnt[s] >= (SLOW[s] ? 2 : 0)) begin
        S_READY[s] <= 1'b1;
        // a write folds its data into the answer so write data and direction are checked too
        S_RDATA[s*32+:32] <= {13'h0, 3'(s), S_ADDR[s*32+:16]} ^ (S_WRITE[s] ? S_WDATA[s*32+:32] : 32'h0);
      end else begin
        S_READY[s] <= 1'b0;
        S_RDATA[s*32+:32] <= ~S_RDATA[s*32+:32];
        cnt[s] <= S_REQ[s] ? cnt[s] + 1 : 0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/bmx_matrix_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// matrix port checker
// ****************************************
module bmx_matrix_checker (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [5:0] M_REQ,
  input wire logic [5:0] M_DONE,
  input wire logic [5:0] M_ABORT,
  input wire logic [4:0] S_REQ,
  input wire logic [4:0] S_READY,
  input wire logic [14:0] S_MASTER,
  input wire logic BOOT_SELECT_PIN,
  input wire logic BOOT_SELECT_CAPTURED,
  input wire logic CFG_WRITE,
  input wire logic CFG_VOLTAGE_IN,
  input wire logic CFG_SLEW_IN,
  input wire logic EXT_BUS_VOLTAGE_SELECT,
  input wire logic EXT_BUS_SLEW_SELECT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  a_no_restricted: assert property (!(S_REQ[2] && S_MASTER[8:6] > 2) && !(S_REQ[4] && S_MASTER[14:12] > 2))
    else $error("restricted master owns rom or peripherals");
  a_boot_capture: assert property ($rose(RESET_N) |=> BOOT_SELECT_CAPTURED == $past(BOOT_SELECT_PIN))
    else $error("boot select not captured at release");
  a_boot_held: assert property ($past(RESET_N, 2) && $past(RESET_N) |-> $stable(BOOT_SELECT_CAPTURED))
    else $error("captured boot select changed");
  a_cfg_reset: assert property ($rose(RESET_N) |-> !EXT_BUS_VOLTAGE_SELECT && !EXT_BUS_SLEW_SELECT)
    else $error("config not at reset defaults");
  a_cfg_load: assert property (CFG_WRITE |=> EXT_BUS_VOLTAGE_SELECT == $past(CFG_VOLTAGE_IN)
    && EXT_BUS_SLEW_SELECT == $past(CFG_SLEW_IN))
    else $error("config write not loaded");
  a_cfg_hold: assert property (!CFG_WRITE |=> $stable({EXT_BUS_VOLTAGE_SELECT, EXT_BUS_SLEW_SELECT}))
    else $error("config changed without write");
  a_answer_single: assert property (((M_DONE | M_ABORT) & $past(M_DONE | M_ABORT)) == 0 && (M_DONE & M_ABORT) == 0)
    else $error("answer longer than one cycle or both kinds");
  a_done_requested: assert property ((M_DONE & ~$past(M_REQ)) == 0)
    else $error("done without request");
  genvar s;
  // a waiting slave keeps its owner; a ready slave answers its owner next cycle
  for (s = 0; s < 5; s++) begin : g_sl
    a_owner_hold: assert property (S_REQ[s] && !S_READY[s] |=> S_REQ[s] && $stable(S_MASTER[s*3+:3]))
      else $error("slave owner changed while waiting");
    a_slave_served: assert property (S_REQ[s] && S_READY[s] |=> !S_REQ[s] && M_DONE[$past(S_MASTER[s*3+:3])])
      else $error("ready slave did not complete owner");
  end
  c_abort: cover property (|M_ABORT);
  c_parallel: cover property (S_REQ[0] && S_REQ[1]);
  c_remote: cover property (S_REQ[3] && S_READY[3]);
endmodule
bind bmx_matrix bmx_matrix_checker i_bmx_matrix_checker (.MCLK(MCLK), .RESET_N(RESET_N), .M_REQ(M_REQ),
  .M_DONE(M_DONE), .M_ABORT(M_ABORT), .S_REQ(S_REQ), .S_READY(S_READY), .S_MASTER(S_MASTER),
  .BOOT_SELECT_PIN(BOOT_SELECT_PIN), .BOOT_SELECT_CAPTURED(BOOT_SELECT_CAPTURED), .CFG_WRITE(CFG_WRITE),
  .CFG_VOLTAGE_IN(CFG_VOLTAGE_IN), .CFG_SLEW_IN(CFG_SLEW_IN), .EXT_BUS_VOLTAGE_SELECT(EXT_BUS_VOLTAGE_SELECT),
  .EXT_BUS_SLEW_SELECT(EXT_BUS_SLEW_SELECT));
`default_nettype wire

// ==== testbench/bmx_matrix_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bmx_defs.vh"
// ****************************************
// matrix testbench
// ****************************************
module bmx_matrix_tb;
  logic mclk = 0, reset_n = 0, remap = 0, boot_pin = 0, boot_exp = 0, cfg_write = 0, cfg_v = 0, cfg_s = 0;
  logic [5:0] m_req = 0, m_write = 0, m_last = 0, m_done, m_abort;
  logic [191:0] m_addr = 0, m_wdata = 0, m_rdata;
  logic [4:0] s_req, s_write, s_ready, arb_pol = 0, slow = 0;
  logic [159:0] s_addr, s_wdata, s_rdata;
  logic [14:0] s_master, arb_dm = 0;
  logic [9:0] arb_mode = 0;
  logic [39:0] arb_slot = 0;
  logic boot_cap, volt, slew;
  logic [31:0] seed = 32'hc3b8c99e;
  int err_count = 0, comparisons = 0, cyc = 0, snap = 0, nb [6], t_done [6];
  always #5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  bmx_matrix i_bmx_matrix (.MCLK(mclk), .RESET_N(reset_n), .M_REQ(m_req), .M_ADDR(m_addr), .M_WRITE(m_write),
    .M_WDATA(m_wdata), .M_LAST(m_last), .M_DONE(m_done), .M_ABORT(m_abort), .M_RDATA(m_rdata), .S_REQ(s_req),
    .S_ADDR(s_addr), .S_WRITE(s_write), .S_WDATA(s_wdata), .S_MASTER(s_master), .S_RDATA(s_rdata),
    .S_READY(s_ready), .ARB_POLICY(arb_pol), .ARB_DEF_MODE(arb_mode), .ARB_DEF_MASTER(arb_dm),
    .ARB_SLOT_LIMIT(arb_slot), .REMAP(remap), .BOOT_SELECT_PIN(boot_pin), .BOOT_SELECT_CAPTURED(boot_cap),
    .CFG_WRITE(cfg_write), .CFG_VOLTAGE_IN(cfg_v), .CFG_SLEW_IN(cfg_s), .EXT_BUS_VOLTAGE_SELECT(volt),
    .EXT_BUS_SLEW_SELECT(slew));
  bmx_slave_model i_bmx_slave_model (.MCLK(mclk), .S_REQ(s_req), .S_ADDR(s_addr), .S_WRITE(s_write),
    .S_WDATA(s_wdata), .SLOW(slow),
    .S_RDATA(s_rdata), .S_READY(s_ready));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // expected slave for a master and address; restricted masters lose rom and peripherals
  function automatic logic [2:0] exp_slave(int m, logic [31:0] a);
    logic [2:0] s;
    s = `BMX_SL_EBI;
    if (a[31:28] == 4'h0) begin
      case (a[27:20])
        8'h00: s = remap ? `BMX_SL_SRAM0 : (boot_exp ? `BMX_SL_ROM : `BMX_SL_EBI);
        8'h01, 8'h05: s = `BMX_SL_ROM;
        8'h02: s = `BMX_SL_SRAM0;
        8'h03: s = `BMX_SL_SRAM1;
        default: s = `BMX_SL_NONE;
      endcase
    end else if (a[31:28] == 4'hf) s = `BMX_SL_PERIPH;
    else if (a[31:28] > 4'h7) s = `BMX_SL_NONE;
    if (m > 2 && (s == `BMX_SL_ROM || s == `BMX_SL_PERIPH)) s = `BMX_SL_NONE;
    return s;
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one beat, entered at a falling edge; request held until answered, left high for a next beat
  task automatic xfer(int m, logic [31:0] a, logic last);
    logic [2:0] sl;
    int n;
    sl = exp_slave(m, a);
    m_req[m] = 1'b1;
    m_addr[m*32+:32] = a;
    m_write[m] = a[2];
    m_wdata[m*32+:32] = ~a;
    m_last[m] = last;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (m_done[m] !== 1'b1 && m_abort[m] !== 1'b1 && n < 60);
    nb[m]++;
    t_done[m] = cyc;
    check("answered", m_done[m] | m_abort[m], 1'b1);
    check("abort", m_abort[m], sl == `BMX_SL_NONE);
    if (sl != `BMX_SL_NONE) check("rdata", m_rdata[m*32+:32], {13'h0, sl, a[15:0]} ^ (a[2] ? ~a : 32'h0));
  endtask
  task automatic single(int m, logic [31:0] a);
    @(negedge mclk);
    xfer(m, a, 1'b1);
    m_req[m] = 1'b0;
  endtask
  task automatic burst(int m, logic undef);
    @(negedge mclk);
    for (int i = 0; i < 4; i++) xfer(m, 32'h0020_0000 + 32'(i * 4), !undef && i == 3);
    m_req[m] = 1'b0;
  endtask
  task automatic do_reset(logic b);
    reset_n = 0;
    boot_pin = b;
    repeat (16) @(negedge mclk);
    reset_n = 1;
    boot_exp = b;
    remap = 0;
    repeat (2) @(negedge mclk);
    check("voltage", volt, `BMX_VSEL_3V3);
    check("slew", slew, `BMX_SLEW_FAST);
    check("boot", boot_cap, b);
    boot_pin = ~b;
    @(negedge mclk);
    check("boot held", boot_cap, b);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    do_reset(0);
    single(0, 32'h0000_0010);
    single(3, 32'h0000_0020);
    cfg_write = 1;
    cfg_v = `BMX_VSEL_1V8;
    cfg_s = `BMX_SLEW_SLOW;
    @(negedge mclk);
    cfg_write = 0;
    check("cfg", {volt, slew}, {`BMX_VSEL_1V8, `BMX_SLEW_SLOW});
    do_reset(1);
    single(1, 32'h0000_0030);
    single(4, 32'h0000_0040);
    remap = 1;
    single(0, 32'h0000_0050);
    single(5, 32'h0000_0060);
    // random master, bank and area, boot view and slave speed
    for (int i = 0; i < 120; i++) begin
      seed = lfsr(seed);
      remap = seed[4];
      slow = seed[9:5];
      if (seed[0]) single(seed[10:8] % 6, {9'h0, seed[3:1], seed[19:0]});
      else single(seed[10:8] % 6, seed);
    end
    slow = 0;
    fork
      single(0, 32'h0020_0010);
      single(3, 32'h0030_0020);
    join
    check("parallel", t_done[0], t_done[3]);
    // fixed priority, then round robin with each default master mode
    for (int p = 0; p < 4; p++) begin
      arb_pol[1] = p != 0;
      arb_mode[3:2] = 2'(p - 1);
      arb_dm[5:3] = `BMX_M_ETH;
      fork
        single(1, 32'h0030_0100);
        single(4, 32'h0030_0200);
      join
      if (p == 0) check("fixed", t_done[1] < t_done[4], 1);
      if (p == 1) check("rr none", t_done[1] < t_done[4], 1);
      if (p == 2) check("rr last", t_done[4] < t_done[1], 1);
      if (p == 3) check("default", t_done[4] < t_done[1], 1);
    end
    // burst of four: a limit of two lets the waiting master in after two beats
    for (int lim = 2; lim >= 0; lim -= 2) begin
      arb_slot[7:0] = 8'(lim);
      nb[2] = 0;
      fork
        burst(2, lim != 0);
        begin
          repeat (2) @(negedge mclk);
          single(1, 32'h0020_0040);
          snap = nb[2];
        end
      join
      check("slot break", snap, lim != 0 ? 2 : 4);
    end
    print_verdict;
  end
  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
